//--- verilog/kwu_defs.vh
// Purpose: constants for the key wakeup unit
// Assumes: 32-bit AHB-Lite register access, 20 MHz clock
// Notes: register indices and field positions follow
`ifndef KWSR_DEFS_VH
`define KWSR_DEFS_VH
// Register word indices; byte address is four times the index
`define KWSR_IDX_CTRL_LOW 12'hfc4
`define KWSR_IDX_CTRL_HIGH 12'hfc5
`define KWSR_IDX_STOP_CTRL 12'hfc6
`define KWSR_IDX_STATUS 12'hfc7
// Reset value of both key control registers
`define KWSR_CTRL_RESET 8'h00
// Stop control fields
`define KWSR_STOP_REQ_BIT 0
`define KWSR_LEVEL_MODE_BIT 1
// Warm-up length after release, a plain default
`define KWSR_WARMUP_CYCLES 16'h0010
`endif

//--- verilog/kwu_key_match.v
// Purpose: one key input release-level match
// Assumes: input already synchronised
// Notes: instanced once per key
`timescale 1ns/1ps
`default_nettype none
module kwsr_key_match (
   // Key state and its control pair
   input wire key_i,
   input wire enable_i,
   input wire level_i,
   // Match result
   output wire match_o
);
   // Enabled key whose level equals the chosen release level
   assign match_o = enable_i & ~(key_i ^ level_i);
endmodule
`default_nettype wire

//--- verilog/kwu_top.v
// Purpose: key wakeup unit with STOP entry/release sequencing
// Assumes: AHB-Lite slave, zero wait states, single clock CLOCK_I
// Notes: STOP request and status live in added registers
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "kwu_defs.vh"
module kwsr_top (
   // Clock and reset
   input wire CLOCK_I,
   input wire RST_N_I,
   // AHB-Lite slave
   input wire HSEL_I,
   input wire [31:0] HADDR_I,
   input wire [1:0] HTRANS_I,
   input wire HWRITE_I,
   input wire [2:0] HSIZE_I,
   input wire [31:0] HWDATA_I,
   input wire HREADY_I,
   output reg [31:0] HRDATA_O,
   output reg HREADYOUT_O,
   output reg HRESP_O,
   // Wakeup pins
   input wire STOP_RELEASE_I,
   input wire [7:0] KEY_INPUT_I,
   // Power state
   output reg STOP_MODE_O,
   output reg WAKE_REQ_O
);
   // STOP sequencer states
   localparam ST_RUN = 2'h0;
   localparam ST_STOP = 2'h1;
   localparam ST_WARM = 2'h2;

   // Reset release chain
   reg rst_meta;
   reg rst_sync;
   // Pin synchronisers, stop-release pin in bit 8
   reg [8:0] pin_meta;
   reg [8:0] pin_sync;
   // Software-visible state
   reg [7:0] key_wake_ctrl_low;
   reg [7:0] key_wake_ctrl_high;
   reg level_mode;
   // Sequencer state
   reg [1:0] state;
   reg [15:0] warm_cnt;
   reg skipped;
   // Captured address phase
   reg ph_valid;
   reg ph_write;
   reg [11:0] ph_idx;
   // Combinational helpers
   wire [15:0] ctrl_all;
   wire [7:0] key_match;
   wire wake;
   wire [11:0] a_idx;
   wire wr_stop;

   // Reset release through two flops
   always @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // Pins are asynchronous; only the second stage is read
   always @(posedge CLOCK_I or negedge rst_sync) begin
      if (!rst_sync) begin
         pin_meta <= 9'h000;
         pin_sync <= 9'h000;
      end else begin
         pin_meta <= {STOP_RELEASE_I, KEY_INPUT_I};
         pin_sync <= pin_meta;
      end
   end

   assign ctrl_all = {key_wake_ctrl_high, key_wake_ctrl_low};

   // Per-key matchers, pair k sits at bits 2k (enable) and 2k+1 (level)
   genvar k;
   generate
      for (k = 0; k < 8; k = k + 1) begin : g_key
         kwsr_key_match u_match (
            .key_i(pin_sync[k]),
            .enable_i(ctrl_all[2*k]),
            .level_i(ctrl_all[2*k+1]),
            .match_o(key_match[k])
         );
      end
   endgenerate

   // Stop-release pin has no disable, always a source
   assign wake = pin_sync[8] | (|key_match);

   // Bus address phase capture; word index from byte address
   // Index needs twelve bits, higher address bits alias
   assign a_idx = HADDR_I[13:2];
   always @(posedge CLOCK_I or negedge rst_sync) begin
      if (!rst_sync) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_idx <= 12'h000;
      end else if (HREADY_I) begin
         ph_valid <= HSEL_I & HTRANS_I[1];
         ph_write <= HWRITE_I;
         ph_idx <= a_idx;
      end
   end

   // Write data phase to the stop control word
   assign wr_stop = ph_valid & ph_write & (ph_idx == `KWSR_IDX_STOP_CTRL);

   // Control register writes
   always @(posedge CLOCK_I or negedge rst_sync) begin
      if (!rst_sync) begin
         key_wake_ctrl_low <= `KWSR_CTRL_RESET;
         key_wake_ctrl_high <= `KWSR_CTRL_RESET;
         level_mode <= 1'b1;
      end else if (ph_valid & ph_write) begin
         if (ph_idx == `KWSR_IDX_CTRL_LOW)
            key_wake_ctrl_low <= HWDATA_I[7:0];
         if (ph_idx == `KWSR_IDX_CTRL_HIGH)
            key_wake_ctrl_high <= HWDATA_I[7:0];
         if (ph_idx == `KWSR_IDX_STOP_CTRL)
            level_mode <= HWDATA_I[`KWSR_LEVEL_MODE_BIT];
      end
   end

   // Read data for the current data phase; zero wait states
   always @(posedge CLOCK_I or negedge rst_sync) begin
      if (!rst_sync) begin
         HRDATA_O <= 32'h00000000;
         HREADYOUT_O <= 1'b1;
         HRESP_O <= 1'b0;
      end else begin
         HREADYOUT_O <= 1'b1;
         HRESP_O <= 1'b0;
         if (HREADY_I & HSEL_I & HTRANS_I[1] & ~HWRITE_I) begin
            case (a_idx)
               `KWSR_IDX_CTRL_LOW: HRDATA_O <= {24'h000000, key_wake_ctrl_low};
               `KWSR_IDX_CTRL_HIGH: HRDATA_O <= {24'h000000, key_wake_ctrl_high};
               `KWSR_IDX_STOP_CTRL: HRDATA_O <= {30'h00000000, level_mode, 1'b0};
               `KWSR_IDX_STATUS: HRDATA_O <= {21'h000000, key_match, skipped,
                                             wake, STOP_MODE_O};
               default: HRDATA_O <= 32'h00000000; // Unmapped reads as zero
            endcase
         end
      end
   end

   // STOP sequencer: run, stop, warm-up
   // Edge release mode is not modelled; software keeps level mode
   always @(posedge CLOCK_I or negedge rst_sync) begin
      if (!rst_sync) begin
         state <= ST_RUN;
         warm_cnt <= 16'h0000;
         skipped <= 1'b0;
         STOP_MODE_O <= 1'b0;
         WAKE_REQ_O <= 1'b0;
      end else begin
         WAKE_REQ_O <= wake;
         case (state)
            ST_RUN: begin
               if (wr_stop & HWDATA_I[`KWSR_STOP_REQ_BIT]) begin
                  if (wake) begin
                     skipped <= 1'b1;
                  end else begin
                     skipped <= 1'b0;
                     state <= ST_STOP;
                     STOP_MODE_O <= 1'b1;
                  end
               end
            end
            ST_STOP: begin
               if (wake) begin
                  state <= ST_WARM;
                  warm_cnt <= `KWSR_WARMUP_CYCLES;
               end
            end
            ST_WARM: begin
               if (warm_cnt == 16'h0001) begin
                  state <= ST_RUN;
                  STOP_MODE_O <= 1'b0;
               end
               warm_cnt <= warm_cnt - 16'h0001;
            end
            default: begin
               state <= ST_RUN;
               STOP_MODE_O <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

//--- test/kwu_src.sv
// Purpose: key switch and stop pin source
// Assumes: bench sets wanted levels
// Notes: pins follow one edge late
`timescale 1ns/1ps
`default_nettype none
module kwsr_src (
   // Wanted levels in, pin levels out, stop pin in bit 8
   input wire logic clk_i,
   input wire logic [8:0] lvl_i,
   output logic [8:0] pin_o
);
   // Stop pin follows the bench like the keys, so it also wakes whenever lvl_i[8] is high
   always @(posedge clk_i) pin_o <= lvl_i;
endmodule
`default_nettype wire

//--- test/kwu_chk.sv
// Purpose: port checker for kwsr_top
// Assumes: wake shows 3 edges after pins
// Notes: bound at the foot
`timescale 1ns/1ps
`default_nettype none
module kwsr_chk (
   // Watched ports
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic HREADYOUT_O,
   input wire logic HRESP_O,
   input wire logic STOP_RELEASE_I,
   input wire logic STOP_MODE_O,
   input wire logic WAKE_REQ_O
);
   // One clock domain, reset masks all
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   sequence pin_hi; STOP_RELEASE_I [*4]; endsequence
   sequence woke; STOP_MODE_O && WAKE_REQ_O; endsequence
   sequence entry; $rose(STOP_MODE_O); endsequence
   pin_wake_a: assert property (pin_hi |-> WAKE_REQ_O) else $error("no wake");
   stop_exit_a: assert property (woke |-> ##[1:24] !STOP_MODE_O) else $error("stop held");
   warm_up_a: assert property ($rose(WAKE_REQ_O) && STOP_MODE_O |=> STOP_MODE_O [*8])
      else $error("short warm-up");
   skip_stop_a: assert property (entry |-> !WAKE_REQ_O) else $error("stop on wake");
   entry_hold_a: assert property (entry |=> STOP_MODE_O) else $error("stop dropped");
   reset_out_a: assert property ($rose(RST_N_I) |-> !STOP_MODE_O && !WAKE_REQ_O) else $error("rst");
   ready_hi_a: assert property (HREADYOUT_O) else $error("not ready");
   resp_ok_a: assert property (!HRESP_O) else $error("bad resp");
endmodule
bind kwsr_top kwsr_chk u_kwsr_chk (.CLOCK_I, .RST_N_I, .HREADYOUT_O, .HRESP_O, .STOP_RELEASE_I,
   .STOP_MODE_O, .WAKE_REQ_O);
`default_nettype wire

//--- test/testbench.sv
// Purpose: bench for kwsr_top
// Assumes: zero-wait bus
// Notes: seeded random key levels
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 0, rst_n = 0, hw = 0, hr, hy, sm, wr;
   logic [1:0] ht = 2'h0;
   logic [8:0] lv = 9'h000, pin;
   logic [15:0] cfg;
   logic [31:0] ha = 32'h0, hd = 32'h0, rd, hrd;
   integer n_mismatch = 0, checks_done = 0, seed = 3, i;
   // Clock and far side
   initial forever #25 clk = ~clk;
   kwsr_src u_kwsr_src (.clk_i(clk), .lvl_i(lv), .pin_o(pin));
   kwsr_top u_kwsr_top (.CLOCK_I(clk), .RST_N_I(rst_n), .HSEL_I(1'b1), .HADDR_I(ha),
      .HTRANS_I(ht), .HWRITE_I(hw), .HSIZE_I(3'h2), .HWDATA_I(hd), .HREADY_I(hy),
      .HRDATA_O(hrd), .HREADYOUT_O(hy), .HRESP_O(hr), .STOP_RELEASE_I(pin[8]),
      .KEY_INPUT_I(pin[7:0]), .STOP_MODE_O(sm), .WAKE_REQ_O(wr));
   // Word transfer, each phase held until ready
   task xf(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      ht <= 2'h2;
      ha <= a;
      hw <= w;
      do @(posedge clk); while (hy !== 1'b1);
      ht <= 2'h0;
      hd <= d;
      do @(posedge clk); while (hy !== 1'b1);
      rd = hrd;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) n_mismatch++;
      if (s !== e) $display("[ERR] %s exp %h seen %h", nm, e, s);
   endtask
   // Stop pin high, or an enabled key at its level
   function logic [31:0] wk(input logic [15:0] c, input logic [8:0] p);
      wk = {31'h0, p[8]};
      for (int j = 0; j < 8; j++) if (c[2*j] && p[j] == c[2*j+1]) wk = 32'h1;
   endfunction
   task end_of_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Watchdog well past the planned run
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      end_of_test;
   end
   // Reset, registers, random levels, then stop entry, skip and release
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      xf(1'b0, 32'h3f14, 32'h0);
      chk("ctrl_high", rd, 32'h0);
      xf(1'b0, 32'h3f20, 32'h0);
      chk("unmapped", rd, 32'h0);
      for (i = 0; i < 40; i++) begin
         cfg = 16'($random(seed));
         lv <= {i % 4 == 0, 8'($random(seed))};
         xf(1'b1, 32'h3f10, {24'h0, cfg[7:0]});
         xf(1'b1, 32'h3f14, {24'h0, cfg[15:8]});
         xf(1'b0, 32'h3f10 | {29'h0, i[0], 2'h0}, 32'h0);
         chk("ctrl", rd, {24'h0, i[0] ? cfg[15:8] : cfg[7:0]});
         repeat (5) @(posedge clk);
         chk("wake", {31'h0, wr}, wk(cfg, lv));
      end
      // Mid-run reset must clear the random configuration
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      xf(1'b0, 32'h3f14, 32'h0);
      chk("ctrl_high_rst", rd, 32'h0);
      xf(1'b0, 32'h3f10, 32'h0);
      chk("ctrl_low_rst", rd, 32'h0);
      // Release mode bit: level after reset, edge mode stored and read back
      xf(1'b0, 32'h3f18, 32'h0);
      chk("mode_rst", rd, 32'h2);
      xf(1'b1, 32'h3f18, 32'h0);
      xf(1'b0, 32'h3f18, 32'h0);
      chk("mode_edge", rd, 32'h0);
      lv <= 9'h000;
      xf(1'b1, 32'h3f10, 32'h3);
      xf(1'b1, 32'h3f14, 32'h0);
      for (i = 0; i < 3; i++) begin
         repeat (5) @(posedge clk);
         xf(1'b1, 32'h3f18, 32'h3);
         repeat (2) @(posedge clk);
         chk("stop", {31'h0, sm}, {31'h0, i != 1});
         xf(1'b0, 32'h3f1c, 32'h0);
         chk("status", rd, {28'h0, i == 1, i == 1, i == 1, i != 1});
         lv <= {i == 2, 7'h0, i == 0};
         for (int t = 0; t < 40 && sm; t++) @(posedge clk);
         chk("leave", {31'h0, sm}, 32'h0);
      end
      end_of_test;
   end
endmodule
`default_nettype wire
